// ===== rtl/pmc_pkg.sv
/*
 * Shared constants for the power-mode control block: register offsets,
 * field positions, reset values and the reset-cause bit layout.
 * Assumes a byte-wide register port reached by address.
 */
`default_nettype none
package pmc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;

    // ------------------------------------------------------------------
    // power_control fields
    // ------------------------------------------------------------------
    localparam int BAUD_DOUBLE_POS = 7;
    localparam int FRAMING_SEL_POS = 6;
    localparam int RESERVED_POS = 5;
    localparam int COLD_FLAG_POS = 4;
    localparam int USER_HI_POS = 3;
    localparam int USER_LO_POS = 2;
    localparam int POWER_DOWN_POS = 1;
    localparam int IDLE_POS = 0;

    // ------------------------------------------------------------------
    // serial_control field steered by the select bit
    // ------------------------------------------------------------------
    localparam int SERIAL_TOP_POS = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_POR = 8'h10;
    localparam logic [7:0] WARM_KEEP_MASK = 8'h1F;

    // ------------------------------------------------------------------
    // serial modes (two-bit mode field)
    // ------------------------------------------------------------------
    localparam logic [1:0] SERIAL_MODE_1 = 2'h1;
    localparam logic [1:0] SERIAL_MODE_2 = 2'h2;
    localparam logic [1:0] SERIAL_MODE_3 = 2'h3;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_DOWN
    } power_mode_e;

endpackage : pmc_pkg

`default_nettype wire

// ===== rtl/pmc_wake_sync.sv
/*
 * Three-stage synchroniser for asynchronous wake-up request pins.
 * Assumes inputs may change at any time relative to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_wake_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // raw and filtered levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;
    logic [WIDTH-1:0] level_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("pmc_wake_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            meta_q <= async_i;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            level_q <= '0;
        end else begin
            level_q <= (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
        end
    end

    assign level_o = level_q;

endmodule // pmc_wake_sync

`default_nettype wire

// ===== rtl/pmc_serial_route.sv
/*
 * Steering of serial control bit 7 between the mode bit and the framing
 * error flag, plus the baud doubling decision.
 * Assumes the serial port supplies its mode and baud source on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_serial_route
    import pmc_pkg::*;
(
    // select inputs
    input wire logic framing_access_select_i,
    input wire logic baud_double_i,
    input wire logic [1:0] serial_mode_i,
    input wire logic timer1_baud_i,
    // bit 7 access from the register port
    input wire logic top_write_i,
    input wire logic top_wdata_i,
    input wire logic serial_mode_bit_i,
    input wire logic framing_error_flag_i,
    // steered results
    output logic mode_bit_we_o,
    output logic framing_we_o,
    output logic top_rdata_o,
    output logic baud_x2_o
);

    always_comb begin
        mode_bit_we_o = top_write_i & ~framing_access_select_i; // see R2
        framing_we_o = top_write_i & framing_access_select_i; // see R2
        top_rdata_o = framing_access_select_i ? framing_error_flag_i : serial_mode_bit_i;
    end

    // doubling applies to mode 2, and to modes 1/3 only on timer 1 baud
    always_comb begin
        baud_x2_o = 1'b0;
        if (baud_double_i) begin
            if (serial_mode_i == SERIAL_MODE_2) begin
                baud_x2_o = 1'b1; // see R1
            end else if ((serial_mode_i == SERIAL_MODE_1 || serial_mode_i == SERIAL_MODE_3)
                         && timer1_baud_i) begin
                baud_x2_o = 1'b1; // see R1
            end
        end
    end

    logic unused_wdata;
    assign unused_wdata = top_wdata_i;

endmodule // pmc_serial_route

`default_nettype wire

// ===== rtl/power_mode_control.sv
/*
 * Power control register and power-mode sequencer: idle and power-down
 * entry, clock gating enables, interrupt wake-up, cold-reset flag, user
 * flags and serial-port bit-7 steering plus baud doubling.
 * Assumes the CPU core holds its PC while cpu_clk_en_o is low, and that
 * the interrupt controller runs the waking source's service routine and
 * returns to the next instruction once the core is released.
 */
// Design decision made here: the address-and-strobe port.
// Functional notes
// R1: baud_double doubles baud in qualifying serial modes
// R2: select bit steers serial bit 7 access
// R3: power-on reset sets the cold-reset flag
// R4: other resets leave cold-reset flag unchanged
// R5: software clears cold-reset flag after reading
// R6: two free software flags at bits 3,2
// R7: power-down stops CPU and peripheral clocks
// R8: power-down wake clears bit, runs wake routine
// R9: after routine, resume after the entering instruction
// R10: both bits set means power-down only
// R11: idle stops CPU clock, peripherals keep running
// R12: idle wake clears bit, runs wake routine
// R13: after idle routine, continue at next instruction
// R14: power-on reads 0x10; warm keeps low bits (here bits 4..2 kept, mode bits 1,0 cleared)
// R15: reserved bit 5 reads zero, ignores writes
`timescale 1ns/1ps
`default_nettype none

module power_mode_control
    import pmc_pkg::*;
#(
    parameter int WAKE_SOURCES = 4
) (
    // clock and resets
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic por_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // wake-up sources
    input wire logic [WAKE_SOURCES-1:0] wake_irq_i,
    input wire logic [WAKE_SOURCES-1:0] wake_pin_i,
    // serial port side
    input wire logic [1:0] serial_mode_i,
    input wire logic timer1_baud_i,
    input wire logic serial_mode_bit_i,
    input wire logic framing_error_flag_i,
    output logic serial_mode_bit_we_o,
    output logic framing_error_we_o,
    output logic serial_top_wdata_o,
    output logic baud_x2_o,
    // clock enables and core handshake
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic wake_service_o,
    output logic [WAKE_SOURCES-1:0] wake_source_o,
    output logic [1:0] power_mode_o
);

    if (WAKE_SOURCES < 1 || WAKE_SOURCES > 8) begin : g_bad_sources
        $error("power_mode_control: WAKE_SOURCES must be 1..8");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic baud_double_q;
    logic framing_sel_q;
    logic cold_flag_q;
    logic user_hi_q;
    logic user_lo_q;
    logic power_down_q;
    logic idle_q;
    power_mode_e mode_q;
    power_mode_e mode_d;
    logic [7:0] rdata_q;
    logic wake_service_q;
    logic [WAKE_SOURCES-1:0] wake_source_q;
    logic [WAKE_SOURCES-1:0] pin_level;
    logic [WAKE_SOURCES-1:0] wake_any_vec;
    logic wake;
    logic pc_sel;
    logic sc_sel;
    logic serial_top_rd;
    logic [7:0] pc_read;

    assign pc_sel = addr_i == POWER_CONTROL_ADDR;
    assign sc_sel = addr_i == SERIAL_CONTROL_ADDR;

    // ------------------------------------------------------------------
    // wake sources: pins are asynchronous, interrupts are on clk_i
    // ------------------------------------------------------------------
    pmc_wake_sync #(
        .WIDTH(WAKE_SOURCES)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i(wake_pin_i),
        .level_o(pin_level)
    );

    assign wake_any_vec = wake_irq_i | pin_level;
    assign wake = |wake_any_vec;

    // ------------------------------------------------------------------
    // serial bit-7 steering and baud doubling
    // ------------------------------------------------------------------
    pmc_serial_route u_route (
        .framing_access_select_i(framing_sel_q),
        .baud_double_i(baud_double_q),
        .serial_mode_i(serial_mode_i),
        .timer1_baud_i(timer1_baud_i),
        .top_write_i(wr_i & sc_sel),
        .top_wdata_i(wdata_i[SERIAL_TOP_POS]),
        .serial_mode_bit_i(serial_mode_bit_i),
        .framing_error_flag_i(framing_error_flag_i),
        .mode_bit_we_o(serial_mode_bit_we_o),
        .framing_we_o(framing_error_we_o),
        .top_rdata_o(serial_top_rd),
        .baud_x2_o(baud_x2_o)
    );

    assign serial_top_wdata_o = wdata_i[SERIAL_TOP_POS];

    // ------------------------------------------------------------------
    // serial control bits: warm reset clears them to zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            baud_double_q <= POWER_CONTROL_POR[BAUD_DOUBLE_POS];
            framing_sel_q <= POWER_CONTROL_POR[FRAMING_SEL_POS];
        end else if (!resetn_i) begin
            baud_double_q <= 1'b0;
            framing_sel_q <= 1'b0;
        end else if (wr_i && pc_sel) begin
            baud_double_q <= wdata_i[BAUD_DOUBLE_POS]; // see R1
            framing_sel_q <= wdata_i[FRAMING_SEL_POS]; // see R2
        end
    end

    // ------------------------------------------------------------------
    // cold-reset flag: power-on or a register write of 1 sets it
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            cold_flag_q <= POWER_CONTROL_POR[COLD_FLAG_POS]; // see R3 see R14
        end else if (!resetn_i) begin
            cold_flag_q <= cold_flag_q; // see R4
        end else if (wr_i && pc_sel) begin
            cold_flag_q <= wdata_i[COLD_FLAG_POS]; // see R5
        end
    end

    // ------------------------------------------------------------------
    // user flags: storage only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            user_hi_q <= POWER_CONTROL_POR[USER_HI_POS];
            user_lo_q <= POWER_CONTROL_POR[USER_LO_POS];
        end else if (!resetn_i) begin
            user_hi_q <= user_hi_q; // see R14
            user_lo_q <= user_lo_q;
        end else if (wr_i && pc_sel) begin
            user_hi_q <= wdata_i[USER_HI_POS]; // see R6
            user_lo_q <= wdata_i[USER_LO_POS]; // see R6
        end
    end

    // ------------------------------------------------------------------
    // mode bits: a wake clears them and wins over a same-cycle write,
    // since the core is stopped and cannot be writing then
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            power_down_q <= POWER_CONTROL_POR[POWER_DOWN_POS];
            idle_q <= POWER_CONTROL_POR[IDLE_POS];
        end else if (!resetn_i) begin
            // warm reset must release the core, so the mode bits drop
            power_down_q <= 1'b0;
            idle_q <= 1'b0;
        end else if (mode_q != PM_RUN && wake) begin
            power_down_q <= 1'b0; // see R8
            idle_q <= 1'b0; // see R12 see R10
        end else if (wr_i && pc_sel) begin
            power_down_q <= wdata_i[POWER_DOWN_POS];
            // idle written with power-down is dropped
            idle_q <= wdata_i[IDLE_POS] & ~wdata_i[POWER_DOWN_POS]; // see R10
        end
    end

    // ------------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PM_RUN: begin
                if (power_down_q) begin
                    mode_d = PM_DOWN; // see R10
                end else if (idle_q) begin
                    mode_d = PM_IDLE;
                end
            end
            PM_IDLE: begin
                if (wake) begin
                    mode_d = PM_RUN; // see R12
                end
            end
            PM_DOWN: begin
                if (wake) begin
                    mode_d = PM_RUN; // see R8 see R10
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || por_i) begin
            mode_q <= PM_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // the core holds its PC while stopped, so release resumes in order
    always_comb begin
        cpu_clk_en_o = (mode_q == PM_RUN); // see R7 see R11 see R9 see R13
        periph_clk_en_o = (mode_q != PM_DOWN); // see R7 see R11
        power_mode_o = mode_q;
    end

    // ------------------------------------------------------------------
    // wake report: one pulse naming the waking sources for the core
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i || por_i) begin
            wake_service_q <= 1'b0;
            wake_source_q <= '0;
        end else if (mode_q != PM_RUN && wake) begin
            wake_service_q <= 1'b1; // see R8 see R12
            wake_source_q <= wake_any_vec;
        end else begin
            wake_service_q <= 1'b0;
        end
    end

    assign wake_service_o = wake_service_q;
    assign wake_source_o = wake_source_q;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        pc_read = 8'h00;
        pc_read[BAUD_DOUBLE_POS] = baud_double_q;
        pc_read[FRAMING_SEL_POS] = framing_sel_q;
        pc_read[RESERVED_POS] = 1'b0; // see R15
        pc_read[COLD_FLAG_POS] = cold_flag_q;
        pc_read[USER_HI_POS] = user_hi_q;
        pc_read[USER_LO_POS] = user_lo_q;
        pc_read[POWER_DOWN_POS] = power_down_q;
        pc_read[IDLE_POS] = idle_q;
    end

    // data stands one cycle after the strobe and only then
    always_ff @(posedge clk_i) begin
        if (!resetn_i || por_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i && pc_sel) begin
            rdata_q <= pc_read;
        end else if (rd_i && sc_sel) begin
            rdata_q <= {serial_top_rd, 7'h00}; // see R2
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;

endmodule // power_mode_control

`default_nettype wire

// ===== test/power_mode_control_properties.sv
/*
 * Concurrent checks on the power-mode block, seen from its ports only.
 * Assumes pin wakes are judged by the bench; only wake_irq_i is seen here.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_checker
    import pmc_pkg::*;
#(
    parameter int WAKE_SOURCES = 4
) (
    // clock and resets
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic por_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // wake and serial side
    input wire logic [WAKE_SOURCES-1:0] wake_irq_i,
    input wire logic [1:0] serial_mode_i,
    input wire logic timer1_baud_i,
    input wire logic serial_mode_bit_we_o,
    input wire logic framing_error_we_o,
    input wire logic baud_x2_o,
    // mode outputs
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic wake_service_o,
    input wire logic [WAKE_SOURCES-1:0] wake_source_o,
    input wire logic [1:0] power_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i || por_i);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence s_sleep_wake;
        power_mode_o != PM_RUN && |wake_irq_i;
    endsequence
    sequence s_down_write;
        wr_i && addr_i == POWER_CONTROL_ADDR && wdata_i[POWER_DOWN_POS] && !(|wake_irq_i);
    endsequence
    sequence s_quiet;
        !wr_i && !(|wake_irq_i);
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_idle_clocks: assert property (
        power_mode_o == PM_IDLE |-> !cpu_clk_en_o && periph_clk_en_o)
        else $error("idle mode clock enables wrong");
    a_down_clocks: assert property (
        power_mode_o == PM_DOWN |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("power-down clock enables wrong");
    a_run_clocks: assert property (
        power_mode_o == PM_RUN |-> cpu_clk_en_o && periph_clk_en_o)
        else $error("run mode clock enables wrong");
    a_wake_to_run: assert property (
        s_sleep_wake |=> power_mode_o == PM_RUN && wake_service_o)
        else $error("wake did not return to run");
    a_wake_source_kept: assert property (
        s_sleep_wake |=> wake_source_o == $past(wake_irq_i))
        else $error("wake source not captured");
    a_service_one_cycle: assert property (
        wake_service_o |=> !wake_service_o)
        else $error("wake service pulse too long");
    a_down_entry: assert property (
        s_down_write ##1 s_quiet |=> power_mode_o == PM_DOWN)
        else $error("power-down not entered");
    a_baud_double: assert property (
        baud_x2_o |-> serial_mode_i == SERIAL_MODE_2
            || (serial_mode_i != 2'h0 && timer1_baud_i))
        else $error("baud doubled in wrong mode");
    a_steer_one: assert property (
        wr_i && addr_i == SERIAL_CONTROL_ADDR |-> serial_mode_bit_we_o != framing_error_we_o)
        else $error("serial bit write not steered to one target");
    a_steer_quiet: assert property (
        !(wr_i && addr_i == SERIAL_CONTROL_ADDR) |-> !serial_mode_bit_we_o && !framing_error_we_o)
        else $error("serial bit write without request");
    a_reserved_zero: assert property (
        rd_i && addr_i == POWER_CONTROL_ADDR |=> !rdata_o[RESERVED_POS])
        else $error("reserved bit reads one");
endmodule // pmc_checker

bind power_mode_control pmc_checker #(.WAKE_SOURCES(WAKE_SOURCES)) pmc_checker_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .por_i(por_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .wake_irq_i(wake_irq_i), .serial_mode_i(serial_mode_i), .timer1_baud_i(timer1_baud_i),
    .serial_mode_bit_we_o(serial_mode_bit_we_o), .framing_error_we_o(framing_error_we_o),
    .baud_x2_o(baud_x2_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .wake_service_o(wake_service_o), .wake_source_o(wake_source_o),
    .power_mode_o(power_mode_o)
);

`default_nettype wire

// ===== test/serial_wake_model.sv
/*
 * Far-side model: serial port bit-7 storage and interrupt wake sources.
 * Assumes the block's steered write enables arrive on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_wake_model #(
    parameter int W = 4
) (
    // clock
    input wire logic clk_i,
    // steered serial writes
    input wire logic mode_we_i,
    input wire logic fe_we_i,
    input wire logic wdata_i,
    // wake handshake
    input wire logic service_i,
    output logic [W-1:0] wake_o,
    output logic mode_bit_o,
    output logic fe_o
);
    initial begin
        wake_o = '0;
        mode_bit_o = 1'h0;
        fe_o = 1'h0;
    end

    always @(posedge clk_i) begin
        if (mode_we_i) mode_bit_o <= wdata_i;
        if (fe_we_i) fe_o <= wdata_i;
    end

    // request stays pending until serviced or 50 cycles pass, like a real interrupt flag
    task automatic raise(input logic [W-1:0] src, input int lag);
        repeat (lag + 1) @(posedge clk_i);
        wake_o <= src;
        for (int n = 0; n < 50 && service_i !== 1'h1; n++) @(posedge clk_i);
        wake_o <= '0;
    endtask
endmodule // serial_wake_model

`default_nettype wire

// ===== test/test_power_mode_control.sv
/*
 * Self-checking bench for the power-mode block.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module test_power_mode_control;
    import pmc_pkg::*;
    logic clk_i, resetn_i, por_i, wr_i, rd_i, timer1_baud_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [1:0] serial_mode_i, power_mode_o;
    logic [3:0] wake_irq, wake_pin, wake_source_o;
    logic mode_bit, fe_flag, mode_we, fe_we, top_wdata, baud_x2_o;
    logic cpu_clk_en_o, periph_clk_en_o, wake_service_o;
    int n_mismatch = 0;
    int compares = 0;

    power_mode_control #(.WAKE_SOURCES(4)) power_mode_control_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .por_i(por_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .wake_irq_i(wake_irq), .wake_pin_i(wake_pin),
        .serial_mode_i(serial_mode_i), .timer1_baud_i(timer1_baud_i),
        .serial_mode_bit_i(mode_bit), .framing_error_flag_i(fe_flag),
        .serial_mode_bit_we_o(mode_we), .framing_error_we_o(fe_we),
        .serial_top_wdata_o(top_wdata), .baud_x2_o(baud_x2_o),
        .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
        .wake_service_o(wake_service_o), .wake_source_o(wake_source_o),
        .power_mode_o(power_mode_o)
    );

    serial_wake_model #(.W(4)) serial_wake_model_i (
        .clk_i(clk_i), .mode_we_i(mode_we), .fe_we_i(fe_we), .wdata_i(top_wdata),
        .service_i(wake_service_o), .wake_o(wake_irq), .mode_bit_o(mode_bit), .fe_o(fe_flag)
    );

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string what,
                              input logic [7:0] mask = 8'hFF);
        logic [7:0] v;
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1 v = rdata_o;
        check(what, v & mask, exp);
    endtask

    task automatic check_mode(input logic [1:0] m, input logic cpu, input logic periph);
        check("power mode", 8'(power_mode_o), 8'(m));
        check("cpu clock enable", 8'(cpu_clk_en_o), 8'(cpu));
        check("peripheral clock enable", 8'(periph_clk_en_o), 8'(periph));
    endtask

    task automatic do_reset(input logic cold);
        @(posedge clk_i);
        por_i <= cold;
        resetn_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        por_i <= 1'h0;
        resetn_i <= 1'h1;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_cold_flags();
        read_check(POWER_CONTROL_ADDR, POWER_CONTROL_POR, "cold value");
        bus_write(POWER_CONTROL_ADDR, 8'hEC);
        read_check(POWER_CONTROL_ADDR, 8'hCC, "flags written");
    endtask

    task automatic t_warm_keep();
        bus_write(POWER_CONTROL_ADDR, 8'hDC);
        do_reset(1'h0);
        read_check(POWER_CONTROL_ADDR, 8'h1C, "warm keeps low bits");
        bus_write(POWER_CONTROL_ADDR, 8'h0C); // software clears the cold flag
        do_reset(1'h0);
        read_check(POWER_CONTROL_ADDR, 8'h0C, "warm keeps cleared flag");
        do_reset(1'h1);
        read_check(POWER_CONTROL_ADDR, 8'h10, "cold flag set again");
    endtask

    task automatic t_idle_wake();
        bus_write(POWER_CONTROL_ADDR, 8'h05);
        repeat (2) @(posedge clk_i);
        #1 check_mode(PM_IDLE, 1'h0, 1'h1);
        serial_wake_model_i.raise(4'h2, 3);
        #1 check_mode(PM_RUN, 1'h1, 1'h1);
        check("idle wake source", 8'(wake_source_o), 8'h02);
        bus_write(POWER_CONTROL_ADDR, 8'h05);
        wake_pin <= 4'h4;
        repeat (6) @(posedge clk_i);
        wake_pin <= 4'h0;
        #1 check("pin wake source", 8'(wake_source_o), 8'h04);
        read_check(POWER_CONTROL_ADDR, 8'h04, "idle bit cleared");
    endtask

    task automatic t_down_wake();
        // idle written with power-down must be dropped
        bus_write(POWER_CONTROL_ADDR, 8'h07);
        read_check(POWER_CONTROL_ADDR, 8'h06, "idle dropped");
        check_mode(PM_DOWN, 1'h0, 1'h0);
        serial_wake_model_i.raise(4'h8, 0);
        #1 check_mode(PM_RUN, 1'h1, 1'h1);
        check("down wake source", 8'(wake_source_o), 8'h08);
        read_check(POWER_CONTROL_ADDR, 8'h04, "down bit cleared");
        check_mode(PM_RUN, 1'h1, 1'h1);
    endtask

    task automatic t_serial_route();
        bus_write(SERIAL_CONTROL_ADDR, 8'h80);
        read_check(SERIAL_CONTROL_ADDR, 8'h80, "mode bit path", 8'h80);
        bus_write(POWER_CONTROL_ADDR, 8'h44);
        read_check(SERIAL_CONTROL_ADDR, 8'h00, "framing path", 8'h80);
        bus_write(SERIAL_CONTROL_ADDR, 8'h80);
        bus_write(POWER_CONTROL_ADDR, 8'h04);
        bus_write(SERIAL_CONTROL_ADDR, 8'h00);
        bus_write(POWER_CONTROL_ADDR, 8'h44);
        read_check(SERIAL_CONTROL_ADDR, 8'h80, "framing flag kept", 8'h80);
        check("mode bit cleared", 8'(mode_bit), 8'h00);
    endtask

    task automatic t_baud_table();
        for (int b = 0; b < 2; b++) begin
            bus_write(POWER_CONTROL_ADDR, 8'(b << 7) | 8'h04);
            for (int k = 0; k < 8; k++) begin
                @(posedge clk_i);
                serial_mode_i <= k[1:0];
                timer1_baud_i <= k[2];
                #1 check("baud double", 8'(baud_x2_o),
                         8'(b == 1 && (k[1:0] == 2 || (k[1:0] != 0 && k[2]))));
            end
        end
    endtask

    task automatic t_unmapped();
        bus_write(8'h55, 8'hFF);
        read_check(8'h55, 8'h00, "unmapped read");
        read_check(POWER_CONTROL_ADDR, 8'h84, "register untouched");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        por_i = 1'h1;
        resetn_i = 1'h0;
        wr_i = 1'h0;
        rd_i = 1'h0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        serial_mode_i = 2'h0;
        timer1_baud_i = 1'h0;
        wake_pin = 4'h0;
        repeat (4) @(posedge clk_i);
        por_i <= 1'h0;
        resetn_i <= 1'h1;
        t_cold_flags();
        t_warm_keep();
        t_idle_wake();
        t_down_wake();
        t_serial_route();
        t_baud_table();
        t_unmapped();
        report_and_stop();
    end

    // whole run is about a hundred cycles; this only cuts a hang short
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule // test_power_mode_control

`default_nettype wire
